// ### core/mts_tx_status.sv
// mts_tx_status: transmit status word, control word and interrupt of the mac.
// assumes an apb master on the register side and a transmit engine
// that marks packets and reports link conditions synchronously to clk.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
module mts_tx_status
    import mts_pkg::*;
#(
    parameter int DEFER_10M_CYCLES = DEFER_10M_CYC
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_start,
    input wire logic tx_byte,
    input wire logic tx_end,
    input wire logic tx_discard,
    input wire logic collision_det,
    input wire logic carrier_sense,
    input wire logic fifo_empty,
    input wire logic fifo_parity_err,
    input wire logic deferring,
    input wire logic pause_hold,
    input wire logic link_10m,
    output logic transmit_enable,
    output logic abort_tx,
    output logic irq
);
    // ****************************************
    // register bus
    // ****************************************
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [15:0] ctrl_q;
    logic [15:0] stat_q;
    logic [15:0] irqs_q;
    logic [15:0] mask_q;

    wire acc = psel & penable;
    wire done = acc & pready_q;
    wire wr = done & pwrite;
    wire hit_ctrl = paddr == OFS_TX_CONTROL;
    wire hit_stat = paddr == OFS_TX_STATUS;
    wire hit_irqs = paddr == OFS_IRQ_STATUS;
    wire hit_mask = paddr == OFS_IRQ_MASK;
    wire hit_any = hit_ctrl | hit_stat | hit_irqs | hit_mask;
    wire wr_ctrl = wr & hit_ctrl;
    wire [15:0] stat_w1c = (wr & hit_stat) ? pwdata[15:0] : 16'h0000;
    wire [15:0] irqs_w1c = (wr & hit_irqs) ? pwdata[15:0] : 16'h0000;
    wire [15:0] rd_mux = hit_ctrl ? ctrl_q : hit_stat ? stat_q : hit_irqs ? irqs_q : hit_mask ? mask_q : 16'h0000;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (ce) begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~hit_any;
            prdata_q <= (acc & ~pready_q) ? {16'h0000, rd_mux} : prdata_q;
        end
    end

    // ****************************************
    // packet tracking
    // ****************************************
    mts_pkt_state_type state_q;
    mts_pkt_state_type state_d;
    logic col_q;
    logic [4:0] coll_q;
    logic [6:0] bytes_q;
    logic late_q;
    logic defd_q;
    logic paused_q;
    logic under_q;
    logic deferral_q;
    logic crs_q;
    logic abort_q;
    logic defer_hit;
    logic sqe_fail;

    wire busy = state_q == MTS_BUSY;
    wire col_rise = collision_det & ~col_q;
    wire col_pkt = busy & col_rise;
    wire excess = col_pkt & (coll_q == 5'(EXCESS_COLL - 1));
    wire pkt_end = busy & (tx_end | tx_discard | excess);
    wire past_slot = bytes_q >= 7'(LATE_COLL_BYTES);
    wire [4:0] coll_now = col_pkt ? coll_q + 5'd1 : coll_q;
    wire late_now = late_q | (col_pkt & past_slot);
    wire defd_now = defd_q | deferring;
    wire paused_now = paused_q | pause_hold;
    wire under_now = under_q | fifo_empty;
    wire deferral_now = deferral_q | defer_hit;
    wire crs_now = crs_q | carrier_sense;

    always_comb begin
        state_d = state_q;
        case (state_q)
            MTS_IDLE: begin
                if (tx_start) begin
                    state_d = MTS_BUSY;
                end
            end
            MTS_BUSY: begin
                if (pkt_end) begin
                    state_d = MTS_IDLE;
                end
            end
            default: begin
                state_d = MTS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= MTS_IDLE;
            col_q <= 1'b0;
            coll_q <= 5'h00;
            bytes_q <= 7'h00;
        end else if (ce) begin
            state_q <= state_d;
            col_q <= collision_det;
            coll_q <= (!busy) ? 5'h00 : coll_now;
            bytes_q <= (!busy) ? 7'h00 : (tx_byte & ~past_slot) ? bytes_q + 7'd1 : bytes_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            late_q <= 1'b0;
            defd_q <= 1'b0;
            paused_q <= 1'b0;
            under_q <= 1'b0;
            deferral_q <= 1'b0;
            crs_q <= 1'b0;
        end else if (ce) begin
            late_q <= busy & late_now;
            defd_q <= busy & defd_now;
            paused_q <= busy & paused_now;
            under_q <= busy & under_now;
            deferral_q <= busy & deferral_now;
            crs_q <= busy & crs_now;
        end
    end

    mts_defer_timer #(
        .CYC_10M(DEFER_10M_CYCLES),
        .CYC_100M(DEFER_100M_CYC)
    ) u_defer (
        .clk(clk),
        .ce(ce),
        .sys_rst(sys_rst),
        .deferring(deferring & busy),
        .mode_10m(link_10m),
        .enable(~ctrl_q[CT_NODEF]),
        .limit_hit(defer_hit)
    );

    // sqe check only for a packet that left the wire
    mts_sqe_check #(
        .WIN(SQE_IFG_CYC)
    ) u_sqe (
        .clk(clk),
        .ce(ce),
        .sys_rst(sys_rst),
        .start(pkt_end & ~tx_discard & ~excess & ctrl_q[CT_SQEN]),
        .collision_det(collision_det),
        .sqe_fail(sqe_fail)
    );

    // ****************************************
    // status word and control word
    // ****************************************
    logic [15:0] en_vec;
    logic [15:0] pkt_word;
    logic [15:0] stat_d;
    logic [15:0] ctrl_d;
    logic [15:0] ev;
    logic [15:0] irqs_d;
    logic irq_q;
    logic transmit_enable_q;

    always_comb begin
        en_vec = 16'h0000;
        en_vec[ST_EXCESSIVE_COLLISION_FLAG] = ctrl_q[CT_EN_EXCESSIVE_COLLISION_FLAG];
        en_vec[ST_UNDER] = ctrl_q[CT_EN_UNDER];
        en_vec[ST_DEFERRAL] = ctrl_q[CT_EN_DEFER];
        en_vec[ST_NOCARR] = ctrl_q[CT_EN_MISSING_CARRIER_FLAG];
        en_vec[ST_LATE] = ctrl_q[CT_EN_LATE];
        en_vec[ST_PARITY] = ctrl_q[CT_EN_PAR];
        en_vec[ST_COMP] = ctrl_q[CT_EN_COMP];
    end

    wire par_evt = fifo_parity_err;
    wire halt_evt = wr_ctrl & ((ctrl_q[CT_TRANSMIT_ENABLE] & ~pwdata[CT_TRANSMIT_ENABLE]) | pwdata[CT_HALT_IMM]);

    always_comb begin
        pkt_word = 16'h0000;
        pkt_word[3:0] = excess ? 4'h0 : coll_now[3:0];
        pkt_word[ST_EXCESSIVE_COLLISION_FLAG] = excess;
        pkt_word[ST_DEFERRED] = defd_now;
        pkt_word[ST_PAUSED] = paused_now;
        pkt_word[ST_UNDER] = under_now;
        pkt_word[ST_DEFERRAL] = deferral_now;
        pkt_word[ST_NOCARR] = ~crs_now & ~tx_discard;
        pkt_word[ST_LATE] = late_now;
        pkt_word[ST_COMP] = 1'b1;
        pkt_word[ST_TRANSMIT_INTERRUPT_FLAG] = |(pkt_word & en_vec);
    end

    always_comb begin
        stat_d = stat_q & ~stat_w1c;
        if (pkt_end) begin
            // per-packet fields replaced, sqe, parity and halt kept
            stat_d = (stat_d & 16'hA800) | pkt_word;
        end
        stat_d[ST_SQE] = stat_d[ST_SQE] | sqe_fail;
        stat_d[ST_PARITY] = stat_d[ST_PARITY] | par_evt;
        stat_d[ST_HALTED] = stat_d[ST_HALTED] | halt_evt;
    end

    always_comb begin
        ctrl_d = wr_ctrl ? pwdata[15:0] : ctrl_q;
        if (par_evt & ctrl_q[CT_EN_PAR]) begin
            ctrl_d[CT_TRANSMIT_ENABLE] = 1'b0;
        end
    end

    always_comb begin
        ev = pkt_end ? pkt_word : 16'h0000;
        ev[ST_SQE] = sqe_fail;
        ev[ST_PARITY] = par_evt;
        ev[ST_HALTED] = halt_evt;
        irqs_d = (irqs_q & ~irqs_w1c) | (ev & en_vec);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= RST_TX_STATUS;
            ctrl_q <= RST_TX_CONTROL;
            irqs_q <= 16'h0000;
            mask_q <= RST_IRQ_MASK;
            irq_q <= 1'b0;
            transmit_enable_q <= 1'b0;
            abort_q <= 1'b0;
        end else if (ce) begin
            stat_q <= stat_d;
            ctrl_q <= ctrl_d;
            irqs_q <= irqs_d;
            mask_q <= (wr & hit_mask) ? pwdata[15:0] : mask_q;
            irq_q <= |(irqs_d & mask_q);
            transmit_enable_q <= ctrl_d[CT_TRANSMIT_ENABLE] & ~ctrl_d[CT_HALT_IMM];
            abort_q <= excess;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign transmit_enable = transmit_enable_q;
    assign abort_tx = abort_q;
    assign irq = irq_q;

    // ****************************************
    // checks
    // ****************************************
    sequence s_pkt_excess;
        ce && excess;
    endsequence

    chk_excess_abort: assert property (@(posedge clk) disable iff (sys_rst)
        s_pkt_excess |=> abort_tx && stat_q[ST_EXCESSIVE_COLLISION_FLAG] && stat_q[3:0] == 4'h0)
        else $error("excessive collision not reported");

    chk_count_excl: assert property (@(posedge clk) disable iff (sys_rst)
        stat_q[ST_EXCESSIVE_COLLISION_FLAG] |-> stat_q[3:0] == 4'h0)
        else $error("count nonzero with excessive flag");

    chk_count_value: assert property (@(posedge clk) disable iff (sys_rst)
        ce && pkt_end && !excess |=> stat_q[3:0] == $past(coll_now[3:0]))
        else $error("collision count wrong");

    chk_comp_flag: assert property (@(posedge clk) disable iff (sys_rst)
        ce && pkt_end |=> stat_q[ST_COMP] && state_q == MTS_IDLE)
        else $error("completion flag missing");

    chk_par_clear: assert property (@(posedge clk) disable iff (sys_rst)
        ce && fifo_parity_err && ctrl_q[CT_EN_PAR] |=> stat_q[ST_PARITY] && !ctrl_q[CT_TRANSMIT_ENABLE] && !transmit_enable)
        else $error("parity error handling wrong");

    chk_halt_flag: assert property (@(posedge clk) disable iff (sys_rst)
        ce && halt_evt |=> stat_q[ST_HALTED] && !transmit_enable)
        else $error("halt not flagged");

    chk_sqe_window: assert property (@(posedge clk) disable iff (sys_rst)
        ce && sqe_fail |=> stat_q[ST_SQE])
        else $error("sqe failure not flagged");

    chk_late_coll: assert property (@(posedge clk) disable iff (sys_rst)
        ce && col_pkt && bytes_q >= 7'd64 && !excess ##1 (!ce || !pkt_end)[*1] ##0 1'b1
        |-> late_q || stat_q[ST_LATE])
        else $error("late collision lost");

    chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        ce && |(irqs_d & mask_q) |=> irq)
        else $error("interrupt not raised");

    chk_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
        pready |-> prdata[31:16] == 16'h0000)
        else $error("reserved bits not zero");
endmodule

// ### common/mts_pkg.sv
// mts_pkg: register map, field positions and timing constants
// of the transmit status block; assumes a 10 MHz system clock.
package mts_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] OFS_TX_CONTROL = 16'hA008;
    localparam logic [ADDR_W-1:0] OFS_TX_STATUS = 16'hA00C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 16'hA018;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 16'hA01C;
    localparam logic [15:0] RST_TX_CONTROL = 16'h0000;
    localparam logic [15:0] RST_TX_STATUS = 16'h0000;
    localparam logic [15:0] RST_IRQ_MASK = 16'h0000;

    // ****************************************
    // status word fields
    // ****************************************
    localparam int ST_EXCESSIVE_COLLISION_FLAG = 4;
    localparam int ST_DEFERRED = 5;
    localparam int ST_PAUSED = 6;
    localparam int ST_TRANSMIT_INTERRUPT_FLAG = 7;
    localparam int ST_UNDER = 8;
    localparam int ST_DEFERRAL = 9;
    localparam int ST_NOCARR = 10;
    localparam int ST_SQE = 11;
    localparam int ST_LATE = 12;
    localparam int ST_PARITY = 13;
    localparam int ST_COMP = 14;
    localparam int ST_HALTED = 15;

    // ****************************************
    // control word fields
    // ****************************************
    localparam int CT_TRANSMIT_ENABLE = 0;
    localparam int CT_NODEF = 5;
    localparam int CT_SQEN = 7;
    localparam int CT_EN_UNDER = 8;
    localparam int CT_EN_DEFER = 9;
    localparam int CT_EN_MISSING_CARRIER_FLAG = 10;
    localparam int CT_EN_EXCESSIVE_COLLISION_FLAG = 11;
    localparam int CT_EN_LATE = 12;
    localparam int CT_EN_PAR = 13;
    localparam int CT_EN_COMP = 14;
    localparam int CT_HALT_IMM = 15;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEFER_100M_NS = 327680;
    localparam int DEFER_10M_NS = 3276800;
    localparam int DEFER_100M_CYC = (DEFER_100M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEFER_10M_CYC = (DEFER_10M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SQE_IFG_NS = 6400;
    localparam int SQE_IFG_CYC = SQE_IFG_NS / CLK_PERIOD_NS;
    localparam int LATE_COLL_BYTES = 64;
    localparam int EXCESS_COLL = 16;

    typedef enum logic {
        MTS_IDLE = 1'b0,
        MTS_BUSY = 1'b1
    } mts_pkt_state_type;
endpackage

// ### core/mts_defer_timer.sv
// mts_defer_timer: flags a deferral that lasts the maximum time.
// assumes deferring is a level from the transmit engine, synchronous to clk.
`timescale 1ns/10ps
module mts_defer_timer
    import mts_pkg::*;
#(
    parameter int CYC_10M = DEFER_10M_CYC,
    parameter int CYC_100M = DEFER_100M_CYC
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    input wire logic deferring,
    input wire logic mode_10m,
    input wire logic enable,
    output logic limit_hit
);
    localparam int CW = $clog2(CYC_10M + 1);

    initial begin
        if (CYC_100M < 1 || CYC_10M < CYC_100M) begin
            $error("mts_defer_timer: bad deferral limits");
        end
    end

    logic [CW-1:0] cnt_q;
    logic hit_q;
    wire [CW-1:0] limit = mode_10m ? CW'(CYC_10M) : CW'(CYC_100M);
    wire counting = deferring & enable;
    wire at_last = counting & (cnt_q == limit - CW'(1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= !counting ? '0 : (cnt_q < limit) ? cnt_q + CW'(1) : cnt_q;
            hit_q <= at_last;
        end
    end

    assign limit_hit = hit_q;
endmodule

// ### core/mts_sqe_check.sv
// mts_sqe_check: watches for the sqe test pulse after each packet.
// assumes collision_det is the transceiver's collision level.
`timescale 1ns/10ps
module mts_sqe_check
    import mts_pkg::*;
#(
    parameter int WIN = SQE_IFG_CYC
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic collision_det,
    output logic sqe_fail
);
    localparam int CW = $clog2(WIN + 1);

    initial begin
        if (WIN < 2) begin
            $error("mts_sqe_check: window too short");
        end
    end

    logic armed_q;
    logic seen_q;
    logic fail_q;
    logic [CW-1:0] cnt_q;
    wire last = armed_q & (cnt_q == CW'(WIN - 1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
            seen_q <= 1'b0;
            fail_q <= 1'b0;
            cnt_q <= '0;
        end else if (ce) begin
            armed_q <= start | (armed_q & ~last);
            seen_q <= ~start & (seen_q | (armed_q & collision_det));
            cnt_q <= start ? '0 : armed_q ? cnt_q + CW'(1) : cnt_q;
            fail_q <= last & ~seen_q & ~collision_det;
        end
    end

    assign sqe_fail = fail_q;
endmodule

// ### verif/mts_phy_model.sv
// mts_phy_model: transceiver seen from the mac, carrier, collision and sqe test.
// assumes the bench marks packet activity and passes the packet end strobe.
`timescale 1ns/10ps
module mts_phy_model
    import mts_pkg::*;
#(
    parameter int SQE_DLY = 16,
    parameter int SQE_LEN = 15
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tx_end,
    input wire logic pkt_act,
    input wire logic carr_on,
    input wire logic sqe_on,
    input wire logic coll_req,
    output logic collision_det,
    output logic carrier_sense
);
    // ****************************************
    // sqe test pulse after each packet
    // ****************************************
    int sqe_cnt_q;
    logic sqe_pulse;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sqe_cnt_q <= 0;
        end else if (tx_end && sqe_on) begin
            sqe_cnt_q <= 1;
        end else if (sqe_cnt_q != 0 && sqe_cnt_q < SQE_DLY + SQE_LEN) begin
            sqe_cnt_q <= sqe_cnt_q + 1;
        end else begin
            sqe_cnt_q <= 0;
        end
    end

    // 1.6 us quiet, then 1.5 us of collision
    assign sqe_pulse = (sqe_cnt_q > SQE_DLY);
    assign collision_det = coll_req | sqe_pulse;
    assign carrier_sense = pkt_act & carr_on;
endmodule

// ### verif/mac_tx_status_flags_test.sv
// mac_tx_status_flags_test: self-checking bench of the transmit status block.
// assumes a 10 MHz clock and the apb register map of mts_pkg.
`timescale 1ns/10ps
module mac_tx_status_flags_test
    import mts_pkg::*;
;
    logic clk, sys_rst, ce, psel, penable, pwrite, tx_start, tx_byte, tx_end, tx_discard;
    logic fifo_empty, fifo_parity_err, deferring, pause_hold, link_10m;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic pready, pslverr, err_q, collision_det, carrier_sense, transmit_enable, abort_tx, irq;
    logic pkt_act, carr_on, sqe_on, coll_req;
    int n_fail, cmp_count;
    int n_abort = 0;

    mts_tx_status #(.DEFER_10M_CYCLES(4000)) uut (.clk(clk), .ce(ce), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_start(tx_start),
        .tx_byte(tx_byte), .tx_end(tx_end), .tx_discard(tx_discard),
        .collision_det(collision_det), .carrier_sense(carrier_sense), .fifo_empty(fifo_empty),
        .fifo_parity_err(fifo_parity_err), .deferring(deferring), .pause_hold(pause_hold),
        .link_10m(link_10m), .transmit_enable(transmit_enable), .abort_tx(abort_tx), .irq(irq));

    mts_phy_model phy (.clk(clk), .sys_rst(sys_rst), .tx_end(tx_end), .pkt_act(pkt_act),
        .carr_on(carr_on), .sqe_on(sqe_on), .coll_req(coll_req),
        .collision_det(collision_det), .carrier_sense(carrier_sense));

    // ****************************************
    // common tasks
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (abort_tx === 1'b1) begin
            n_abort++;
        end
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            wrap_up();
        end
    endtask

    // fin: 0 none, 1 sent, 2 discarded
    task automatic pkt(input int nb, input int nc, input int hold, input int fin);
        @(posedge clk);
        pkt_act <= 1'b1;
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        repeat (nb) begin
            @(posedge clk);
            tx_byte <= 1'b1;
            @(posedge clk);
            tx_byte <= 1'b0;
        end
        repeat (nc) begin
            @(posedge clk);
            coll_req <= 1'b1;
            @(posedge clk);
            coll_req <= 1'b0;
        end
        cyc(hold);
        if (fin != 0) begin
            @(posedge clk);
            tx_end <= (fin == 1);
            tx_discard <= (fin == 2);
            @(posedge clk);
            tx_end <= 1'b0;
            tx_discard <= 1'b0;
        end
        pkt_act <= 1'b0;
        fifo_empty <= 1'b0;
        pause_hold <= 1'b0;
        deferring <= 1'b0;
        cyc(2);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("status reset", rd_q, 32'h0);
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        chk("mask reset", rd_q, 32'h0);
        apb(1'b0, 16'hA000, 32'h0);
        chk("unmapped error", {31'h0, err_q}, 32'h1);
        chk("unmapped data", rd_q, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_flags();
        apb(1'b1, OFS_TX_CONTROL, 32'h1);
        carr_on <= 1'b0;
        fifo_empty <= 1'b1;
        pause_hold <= 1'b1;
        deferring <= 1'b1;
        pkt(65, 1, 2, 1);
        carr_on <= 1'b1;
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("packet flags", rd_q & 32'hFFFFFFF0, 32'h5560);
        $display("flags test done");
    endtask

    task automatic t_count();
        apb(1'b1, OFS_TX_CONTROL, 32'h4001);
        pkt(10, 3, 0, 1);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("count status", rd_q, 32'h4083);
        chk("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("irq status", rd_q, 32'h4000);
        apb(1'b1, OFS_IRQ_MASK, 32'hFFFF);
        cyc(2);
        chk("unmasked irq", {31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'hFFFF);
        cyc(2);
        chk("cleared irq", {31'h0, irq}, 32'h0);
        pkt(4, 0, 0, 2);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("discard status", rd_q, 32'h4080);
        apb(1'b1, OFS_IRQ_STATUS, 32'hFFFF);
        $display("count test done");
    endtask

    task automatic t_excess();
        int a0;
        apb(1'b1, OFS_TX_CONTROL, 32'h0801);
        a0 = n_abort;
        pkt(2, 16, 0, 0);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("excess low bits", {27'h0, rd_q[4:0]}, 32'h10);
        chk("abort pulses", 32'(n_abort - a0), 32'h1);
        chk("excess irq", {31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'hFFFF);
        $display("excess test done");
    endtask

    task automatic t_defer();
        apb(1'b1, OFS_TX_CONTROL, 32'h0201);
        link_10m <= 1'b0;
        deferring <= 1'b1;
        pkt(2, 0, 3300, 1);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("deferral 100m", {31'h0, rd_q[ST_DEFERRAL]}, 32'h1);
        chk("deferral irq", {31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'hFFFF);
        apb(1'b1, OFS_TX_STATUS, 32'hFFFF);
        link_10m <= 1'b1;
        deferring <= 1'b1;
        pkt(2, 0, 3300, 1);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("deferral 10m", {31'h0, rd_q[ST_DEFERRAL]}, 32'h0);
        apb(1'b1, OFS_TX_CONTROL, 32'h0221);
        link_10m <= 1'b0;
        deferring <= 1'b1;
        pkt(2, 0, 3300, 1);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("deferral off", {31'h0, rd_q[ST_DEFERRAL]}, 32'h0);
        $display("deferral test done");
    endtask

    task automatic t_sqe();
        apb(1'b1, OFS_TX_CONTROL, 32'h0081);
        sqe_on <= 1'b1;
        pkt(2, 0, 0, 1);
        cyc(80);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("sqe seen", {31'h0, rd_q[ST_SQE]}, 32'h0);
        sqe_on <= 1'b0;
        pkt(2, 0, 0, 1);
        cyc(80);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("sqe missing", {31'h0, rd_q[ST_SQE]}, 32'h1);
        $display("sqe test done");
    endtask

    task automatic t_parity();
        apb(1'b1, OFS_TX_CONTROL, 32'h2001);
        cyc(2);
        chk("enable on", {31'h0, transmit_enable}, 32'h1);
        ce <= 1'b0;
        fifo_parity_err <= 1'b1;
        @(posedge clk);
        fifo_parity_err <= 1'b0;
        ce <= 1'b1;
        cyc(2);
        chk("frozen by ce", {31'h0, transmit_enable}, 32'h1);
        fifo_parity_err <= 1'b1;
        @(posedge clk);
        fifo_parity_err <= 1'b0;
        cyc(3);
        chk("enable cleared", {31'h0, transmit_enable}, 32'h0);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("parity flag", {31'h0, rd_q[ST_PARITY]}, 32'h1);
        chk("parity irq", {31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'hFFFF);
        $display("parity test done");
    endtask

    task automatic t_halt();
        apb(1'b1, OFS_TX_STATUS, 32'hFFFF);
        apb(1'b1, OFS_TX_CONTROL, 32'h1);
        apb(1'b1, OFS_TX_CONTROL, 32'h0);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("halt by enable", {31'h0, rd_q[ST_HALTED]}, 32'h1);
        apb(1'b1, OFS_TX_STATUS, 32'hFFFF);
        apb(1'b1, OFS_TX_CONTROL, 32'h8001);
        cyc(2);
        chk("halt output", {31'h0, transmit_enable}, 32'h0);
        apb(1'b0, OFS_TX_STATUS, 32'h0);
        chk("halt immediate", {31'h0, rd_q[ST_HALTED]}, 32'h1);
        $display("halt test done");
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        {psel, penable, pwrite, tx_start, tx_byte, tx_end, tx_discard} = 7'h00;
        {fifo_empty, fifo_parity_err, deferring, pause_hold, link_10m} = 5'h00;
        {pkt_act, sqe_on, coll_req} = 3'h0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        carr_on = 1'b1;
        ce = 1'b1;
        sys_rst = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_flags();
        t_count();
        t_excess();
        t_defer();
        t_sqe();
        t_parity();
        t_halt();
        wrap_up();
    end

    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule
